// ==== include/sfx_pkg.sv ====
// Shared constants and types for the serial flash extra-command link
package sfx_pkg;
  // Opcodes and sequence bytes
  localparam logic [7:0] OP_QE_LEAD  = 8'h3D;
  localparam logic [7:0] OP_QE_KEY1  = 8'h2A;
  localparam logic [7:0] OP_QE_KEY2  = 8'h81;
  localparam logic [7:0] OP_QE_ON    = 8'h66;
  localparam logic [7:0] OP_QE_OFF   = 8'h67;
  localparam logic [7:0] OP_CFG      = 8'h3F;
  localparam logic [7:0] OP_ASI      = 8'h25;
  localparam logic [7:0] OP_RST      = 8'hF0;
  localparam logic [7:0] OP_RST_PAD  = 8'h00;
  localparam logic [7:0] OP_STAT     = 8'hD7;
  localparam logic [7:0] OP_XFER1    = 8'h53;
  localparam logic [7:0] OP_XFER2    = 8'h55;
  localparam logic [7:0] OP_CMP1     = 8'h60;
  localparam logic [7:0] OP_CMP2     = 8'h61;
  localparam logic [7:0] OP_BWR1     = 8'h58;
  localparam logic [7:0] OP_BWR2     = 8'h59;
  localparam logic [7:0] DUMMY_BYTE  = 8'h00;

  // Address framing
  localparam int         ADDR_W      = 24;
  localparam int         PAGE_W      = 15;
  localparam int         PA_LSB_264  = 9;
  localparam int         PA_LSB_256  = 8;

  // Status and configuration byte layout
  localparam int         RDY_BIT     = 7;
  localparam int         CMP_BIT     = 6;
  localparam logic [3:0] DENSITY     = 4'hD;
  localparam int         CFG_QE_BIT  = 7;
  localparam logic       QE_RESET    = 1'b0;

  // Timing
  localparam int         CLK_NS        = 25;
  localparam int         NV_PROG_NS    = 2000;
  localparam int         BUSY_CYCLES   = (NV_PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int         SCK_HALF_NS   = 50;
  localparam int         SCK_HALF      = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int         CS_HIGH_NS    = 50;
  localparam int         CS_HIGH       = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;

  // Host command kinds
  typedef enum logic [2:0] {
    HC_QE_ON   = 3'h0,
    HC_QE_OFF  = 3'h1,
    HC_RESET   = 3'h2,
    HC_STATUS  = 3'h3,
    HC_CFG     = 3'h4,
    HC_WAIT    = 3'h5,
    HC_PAGE_OP = 3'h6
  } sfx_cmd_t;

  // Page field from the three address bytes, per page-size mode
  function automatic logic [PAGE_W-1:0] sfx_page_of(input logic [ADDR_W-1:0] addr, input logic mode_256);
    sfx_page_of = mode_256 ? addr[PA_LSB_256 +: PAGE_W] : addr[PA_LSB_264 +: PAGE_W];
  endfunction : sfx_page_of

  function automatic logic sfx_is_page_op(input logic [7:0] op);
    sfx_is_page_op = (op == OP_XFER1) || (op == OP_XFER2) || (op == OP_CMP1) ||
                     (op == OP_CMP2) || (op == OP_BWR1) || (op == OP_BWR2);
  endfunction : sfx_is_page_op
endpackage : sfx_pkg

// ==== include/sfx_spi_if.sv ====
// SPI link between host and flash command decoder
`timescale 1ns/1ps
interface sfx_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport dev  (input sclk, input cs_n, input mosi, output miso, output miso_oe);
  modport host (output sclk, output cs_n, output mosi, input miso, input miso_oe);
endinterface : sfx_spi_if

// ==== hw/sfx_dev.sv ====
// Flash-side decoder for quad enable, active status, soft reset and page ops
// Operation
// - Config write only changes quad enable bit
// - 3D 2A 81 66 sets quad enable
// - 3D 2A 81 67 clears quad enable
// - After 25h, output level shows ready
// - Host watches output until ready shown
// - F0 00 00 00 triggers software reset
// - 264 mode: 24 bits, page 15, byte ignored
// - 256 mode: page from A22..A8, no dummies
// - Config read only answered while ready
// - Ready flag bit 7, both status bytes
`timescale 1ns/1ps
module sfx_dev
  import sfx_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // Link
  sfx_spi_if.dev                 spi,
  // Array side
  input  wire logic              page_256,
  input  wire logic              cmp_mismatch,
  output logic                   quad_io_enable_bit,
  output logic                   flash_busy,
  output logic                   op_valid,
  output logic [7:0]             op_code,
  output logic [PAGE_W-1:0]      op_page,
  output logic [7:0]             op_data,
  output logic                   op_has_data,
  output logic                   soft_reset
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPC  = 2'b01,
    ST_BODY = 2'b11
  } sfx_dev_st_t;

  sfx_dev_st_t        st;
  logic               sclk_q;
  logic               cs_q;
  logic [2:0]         bit_cnt;
  logic [2:0]         byte_idx;
  logic               parity;
  logic [6:0]         rx_sh;
  logic [7:0]         opcode;
  logic               seq_ok;
  logic               qe_arm;
  logic               qe_val;
  logic               rst_ok;
  logic               cfg_ok;
  logic [ADDR_W-1:0]  addr;
  logic [7:0]         data;
  logic [6:0]         tx_sh;
  logic [15:0]        busy_cnt;

  wire        sclk_rise  = spi.sclk & ~sclk_q;
  wire        sclk_fall  = ~spi.sclk & sclk_q;
  wire        cs_rise    = spi.cs_n & ~cs_q;
  wire [7:0]  rx_byte    = {rx_sh, spi.mosi};
  wire        byte_done  = ~spi.cs_n & sclk_rise & (bit_cnt == 3'd7);
  wire        ready      = ~flash_busy;
  wire        in_body    = (st == ST_BODY);
  wire        asi_mode   = in_body & (opcode == OP_ASI);
  wire        read_mode  = in_body & ((opcode == OP_STAT) | ((opcode == OP_CFG) & cfg_ok));
  wire        page_op    = sfx_is_page_op(opcode);
  wire        op_ok      = cs_rise & in_body & page_op & (byte_idx >= 3'd4) & ready;
  wire        qe_go      = cs_rise & qe_arm & ready;
  wire        rst_hit    = byte_done & rst_ok & (byte_idx == 3'd3) & (rx_byte == OP_RST_PAD);
  wire        start_busy = op_ok | qe_go;
  wire [7:0]  stat1      = {ready, cmp_mismatch, DENSITY, 1'b0, page_256};
  wire [7:0]  stat2      = {ready, 7'h00};
  wire [7:0]  cfg_byte   = 8'(quad_io_enable_bit) << CFG_QE_BIT;
  wire [7:0]  out_byte   = (opcode == OP_STAT) ? (parity ? stat2 : stat1) : cfg_byte;

  wire [15:0] next_busy_cnt = rst_hit    ? 16'h0000 :
                              start_busy ? 16'(BUSY_CYCLES) :
                              (busy_cnt != 16'h0000) ? busy_cnt - 16'h0001 : 16'h0000;

  // Bit and byte framing; chip select high aborts any partial byte
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q   <= 1'b0;
      cs_q     <= 1'b1;
      bit_cnt  <= 3'h0;
      byte_idx <= 3'h0;
      parity   <= 1'b0;
      rx_sh    <= 7'h00;
      st       <= ST_IDLE;
    end else begin
      sclk_q <= spi.sclk;
      cs_q   <= spi.cs_n;
      if (spi.cs_n) begin
        bit_cnt  <= 3'h0;
        byte_idx <= 3'h0;
        parity   <= 1'b0;
        st       <= ST_IDLE;
      end else if (sclk_rise) begin
        rx_sh   <= rx_byte[6:0];
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'd7) begin
          if (byte_idx != 3'd7) begin
            byte_idx <= byte_idx + 3'h1;
          end
          if (byte_idx != 3'd0) begin
            parity <= ~parity;
          end
          st <= ST_BODY;
        end else if (st == ST_IDLE) begin
          st <= ST_OPC;
        end
      end
    end
  end

  // Command byte decoding
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      opcode <= 8'h00;
      seq_ok <= 1'b0;
      qe_arm <= 1'b0;
      qe_val <= 1'b0;
      rst_ok <= 1'b0;
      cfg_ok <= 1'b0;
      addr   <= '0;
      data   <= 8'h00;
    end else if (spi.cs_n) begin
      // A frame cut short never arms the quad update
      qe_arm <= 1'b0;
      seq_ok <= 1'b0;
      rst_ok <= 1'b0;
    end else if (byte_done) begin
      case (byte_idx)
        3'd0: begin
          opcode <= rx_byte;
          seq_ok <= (rx_byte == OP_QE_LEAD);
          rst_ok <= (rx_byte == OP_RST);
          cfg_ok <= ready;
        end
        3'd1: begin
          seq_ok       <= seq_ok & (rx_byte == OP_QE_KEY1);
          rst_ok       <= rst_ok & (rx_byte == OP_RST_PAD);
          addr[23:16]  <= rx_byte;
        end
        3'd2: begin
          seq_ok       <= seq_ok & (rx_byte == OP_QE_KEY2);
          rst_ok       <= rst_ok & (rx_byte == OP_RST_PAD);
          addr[15:8]   <= rx_byte;
        end
        3'd3: begin
          qe_arm       <= seq_ok & ((rx_byte == OP_QE_ON) | (rx_byte == OP_QE_OFF));
          qe_val       <= (rx_byte == OP_QE_ON);
          rst_ok       <= 1'b0;
          addr[7:0]    <= rx_byte;
        end
        3'd4: begin
          // Extra bytes spoil the quad sequence
          qe_arm <= 1'b0;
          data   <= rx_byte;
        end
        default: begin
          qe_arm <= 1'b0;
        end
      endcase
    end
  end

  // Non-volatile bit, busy timer and array-side pulses
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      quad_io_enable_bit <= QE_RESET;
      busy_cnt           <= 16'h0000;
      flash_busy         <= 1'b0;
      op_valid           <= 1'b0;
      op_code            <= 8'h00;
      op_page            <= '0;
      op_data            <= 8'h00;
      op_has_data        <= 1'b0;
      soft_reset         <= 1'b0;
    end else begin
      busy_cnt   <= next_busy_cnt;
      flash_busy <= (next_busy_cnt != 16'h0000);
      soft_reset <= rst_hit;
      op_valid   <= op_ok;
      if (qe_go) begin
        quad_io_enable_bit <= qe_val;
      end
      if (op_ok) begin
        op_code     <= opcode;
        op_page     <= sfx_page_of(addr, page_256);
        op_data     <= data;
        op_has_data <= (byte_idx >= 3'd5);
      end
    end
  end

  // Serial output: status/config bytes on falling edges, ready level in interrupt mode
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      spi.miso    <= 1'b0;
      spi.miso_oe <= 1'b0;
      tx_sh       <= 7'h00;
    end else if (spi.cs_n) begin
      spi.miso    <= 1'b0;
      spi.miso_oe <= 1'b0;
    end else if (asi_mode) begin
      // Busy holds the line low, ready drives it high
      spi.miso    <= ready;
      spi.miso_oe <= 1'b1;
    end else if (read_mode & sclk_fall) begin
      spi.miso_oe <= 1'b1;
      if (bit_cnt == 3'd0) begin
        spi.miso <= out_byte[7];
        tx_sh    <= out_byte[6:0];
      end else begin
        spi.miso <= tx_sh[6];
        tx_sh    <= {tx_sh[5:0], 1'b0};
      end
    end
  end

endmodule : sfx_dev

// ==== hw/sfx_host.sv ====
// Host-side SPI master issuing the extra flash commands
`timescale 1ns/1ps
module sfx_host
  import sfx_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // Link
  sfx_spi_if.host                spi,
  // Command port
  input  wire logic              cmd_valid,
  input  wire sfx_cmd_t          cmd_kind,
  input  wire logic [7:0]        cmd_op,
  input  wire logic [PAGE_W-1:0] cmd_page,
  input  wire logic [7:0]        cmd_data,
  input  wire logic              page_256,
  output logic                   cmd_ready,
  output logic                   rsp_valid,
  output logic [15:0]            rsp_data
);

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SHIFT = 3'b001,
    H_WAIT  = 3'b011,
    H_END   = 3'b010
  } sfx_host_st_t;

  sfx_host_st_t st;
  logic [47:0]  tx_sh;
  logic [5:0]   bits_left;
  logic [15:0]  rx_sh;
  logic [3:0]   div;
  logic         wait_rdy;

  wire [23:0] addr_264 = {cmd_page, 9'h000};
  wire [23:0] addr_256 = {1'b0, cmd_page, 8'h00};
  wire [23:0] addr     = page_256 ? addr_256 : addr_264;
  wire        with_dat = (cmd_op == OP_BWR1) | (cmd_op == OP_BWR2);

  logic [47:0] frame;
  logic [5:0]  frame_bits;
  always_comb begin
    frame      = '0;
    frame_bits = 6'd8;
    case (cmd_kind)
      HC_QE_ON: begin
        frame      = {OP_QE_LEAD, OP_QE_KEY1, OP_QE_KEY2, OP_QE_ON, 16'h0000};
        frame_bits = 6'd32;
      end
      HC_QE_OFF: begin
        frame      = {OP_QE_LEAD, OP_QE_KEY1, OP_QE_KEY2, OP_QE_OFF, 16'h0000};
        frame_bits = 6'd32;
      end
      HC_RESET: begin
        frame      = {OP_RST, OP_RST_PAD, OP_RST_PAD, OP_RST_PAD, 16'h0000};
        frame_bits = 6'd32;
      end
      HC_STATUS: begin
        frame      = {OP_STAT, DUMMY_BYTE, DUMMY_BYTE, 24'h000000};
        frame_bits = 6'd24;
      end
      HC_CFG: begin
        frame      = {OP_CFG, DUMMY_BYTE, 32'h00000000};
        frame_bits = 6'd16;
      end
      HC_WAIT: begin
        frame      = {OP_ASI, 40'h0000000000};
        frame_bits = 6'd8;
      end
      HC_PAGE_OP: begin
        frame      = {cmd_op, addr, cmd_data, 8'h00};
        frame_bits = with_dat ? 6'd40 : 6'd32;
      end
      default: begin
        frame      = '0;
        frame_bits = 6'd8;
      end
    endcase
  end

  wire half_done = (div == 4'(SCK_HALF - 1));

  // Frame sequencer; clock idles low (mode 0)
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st        <= H_IDLE;
      spi.sclk  <= 1'b0;
      spi.cs_n  <= 1'b1;
      spi.mosi  <= 1'b0;
      tx_sh     <= '0;
      bits_left <= 6'h00;
      rx_sh     <= 16'h0000;
      div       <= 4'h0;
      wait_rdy  <= 1'b0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      case (st)
        H_IDLE: begin
          div <= 4'h0;
          if (cmd_valid & cmd_ready) begin
            cmd_ready <= 1'b0;
            spi.cs_n  <= 1'b0;
            spi.mosi  <= frame[47];
            tx_sh     <= {frame[46:0], 1'b0};
            bits_left <= frame_bits;
            wait_rdy  <= (cmd_kind == HC_WAIT);
            rx_sh     <= 16'h0000;
            st        <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          div <= half_done ? 4'h0 : div + 4'h1;
          if (half_done) begin
            spi.sclk <= ~spi.sclk;
            if (!spi.sclk) begin
              rx_sh <= {rx_sh[14:0], spi.miso};
            end else begin
              spi.mosi  <= tx_sh[47];
              tx_sh     <= {tx_sh[46:0], 1'b0};
              bits_left <= bits_left - 6'h01;
              if (bits_left == 6'h01) begin
                st <= wait_rdy ? H_WAIT : H_END;
              end
            end
          end
        end
        H_WAIT: begin
          // Clock stays still; the output line itself signals ready
          if (spi.miso_oe & spi.miso) begin
            st <= H_END;
          end
        end
        H_END: begin
          spi.cs_n <= 1'b1;
          div      <= div + 4'h1;
          if (div == 4'(CS_HIGH)) begin
            rsp_valid <= 1'b1;
            rsp_data  <= rx_sh;
            cmd_ready <= 1'b1;
            st        <= H_IDLE;
          end
        end
        default: begin
          st <= H_IDLE;
        end
      endcase
    end
  end

endmodule : sfx_host

// ==== test/sfx_link_properties.sv ====
// Timing and framing checks on the SPI wires between host and decoder
`timescale 1ns/1ps
module sfx_link_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  property p_sclk_idle_low;
    cs_n |-> !sclk;
  endproperty
  property p_cs_moves_low;
    $changed(cs_n) |-> !sclk;
  endproperty
  property p_cs_high_min;
    $rose(cs_n) |-> cs_n[*3];
  endproperty
  property p_first_bit_setup;
    $fell(cs_n) |-> !sclk ##1 !sclk ##1 sclk;
  endproperty
  property p_sclk_high_two;
    $rose(sclk) |=> sclk ##1 !sclk;
  endproperty
  property p_mosi_hold;
    sclk |-> $stable(mosi);
  endproperty
  property p_oe_release;
    $rose(cs_n) |-> ##[1:3] !miso_oe;
  endproperty
  property p_oe_idle;
    cs_n && $past(cs_n) && $past(cs_n, 2) |-> !miso_oe;
  endproperty
  property p_oe_after_opcode;
    $fell(cs_n) |-> !miso_oe[*8];
  endproperty

  a_sclk_idle_low: assert property (p_sclk_idle_low)
    else $error("sclk high outside a frame");
  a_cs_moves_low: assert property (p_cs_moves_low)
    else $error("chip select moved while sclk high");
  a_cs_high_min: assert property (p_cs_high_min)
    else $error("chip select high time too short");
  a_first_bit_setup: assert property (p_first_bit_setup)
    else $error("first sclk rise not two cycles after select");
  a_sclk_high_two: assert property (p_sclk_high_two)
    else $error("sclk high phase not two cycles");
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("mosi changed while sclk high");
  a_oe_release: assert property (p_oe_release)
    else $error("miso still driven after deselect");
  a_oe_idle: assert property (p_oe_idle)
    else $error("miso driven while deselected");
  a_oe_after_opcode: assert property (p_oe_after_opcode)
    else $error("miso driven during opcode");

  // Busy-to-ready seen on the wire inside a frame
  c_ready_edge: cover property (!cs_n && miso_oe && !miso ##1 miso_oe && miso);
  c_frame_end: cover property ($rose(cs_n));
  c_drive: cover property (!cs_n && miso_oe && miso);
endmodule : sfx_link_properties

// ==== test/serial_flash_extra_cmd_decoder_bench.sv ====
// Host and decoder joined over the link, compared against expected values built in the bench from the stimulus
`timescale 1ns/1ps
module serial_flash_extra_cmd_decoder_bench
  import sfx_pkg::*;
;
  logic              core_clk;
  logic              sys_rst;
  logic              cmd_valid;
  sfx_cmd_t          cmd_kind;
  logic [7:0]        cmd_op;
  logic [PAGE_W-1:0] cmd_page;
  logic [7:0]        cmd_data;
  logic              page_256;
  logic              cmp_mismatch;
  logic              cmd_ready;
  logic              rsp_valid;
  logic [15:0]       rsp_data;
  logic              quad_io_enable_bit;
  logic              flash_busy;
  logic              op_valid;
  logic [7:0]        op_code;
  logic [PAGE_W-1:0] op_page;
  logic [7:0]        op_data;
  logic              op_has_data;
  logic              soft_reset;
  int                err_total = 0;
  int                checked = 0;
  int                resets_seen = 0;
  logic [31:0]       rng = 32'h0000002E;
  logic [31:0]       got_q[$];
  logic [31:0]       exp_q[$];
  logic [7:0]        ops[6] = '{OP_XFER1, OP_XFER2, OP_CMP1, OP_CMP2, OP_BWR1, OP_BWR2};

  sfx_spi_if spi ();
  sfx_dev u_sfx_dev (.core_clk(core_clk), .sys_rst(sys_rst), .spi(spi), .page_256(page_256),
    .cmp_mismatch(cmp_mismatch), .quad_io_enable_bit(quad_io_enable_bit), .flash_busy(flash_busy),
    .op_valid(op_valid), .op_code(op_code), .op_page(op_page), .op_data(op_data), .op_has_data(op_has_data),
    .soft_reset(soft_reset));
  sfx_host u_sfx_host (.core_clk(core_clk), .sys_rst(sys_rst), .spi(spi), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_op(cmd_op), .cmd_page(cmd_page), .cmd_data(cmd_data), .page_256(page_256),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  sfx_link_properties u_sfx_link_properties (.core_clk(core_clk), .sys_rst(sys_rst), .sclk(spi.sclk),
    .cs_n(spi.cs_n), .mosi(spi.mosi), .miso(spi.miso), .miso_oe(spi.miso_oe));

  function automatic logic [31:0] xs_next(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs_next = s ^ (s << 5);
  endfunction : xs_next

  task automatic end_of_test();
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_flag(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag

  // Pulses last one cycle, so they are caught mid-cycle
  always @(negedge core_clk) begin
    if (op_valid === 1'b1) got_q.push_back({op_code, op_has_data, op_page, op_data});
    if (soft_reset === 1'b1) resets_seen++;
  end

  task automatic issue(input sfx_cmd_t k, input logic [7:0] op, input logic [PAGE_W-1:0] pg,
                       input logic [7:0] d, input logic mode);
    int n;
    @(posedge core_clk);
    rng = xs_next(rng);
    cmd_valid    <= 1'b1;
    cmd_kind     <= k;
    cmd_op       <= op;
    cmd_page     <= pg;
    cmd_data     <= d;
    page_256     <= mode;
    cmp_mismatch <= rng[9];
    n = 0;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    @(negedge core_clk);
    chk_flag("cmd_ready_low", 1'b0, cmd_ready);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 3000);
    chk_flag("rsp_valid", 1'b1, rsp_valid);
    chk_flag("cmd_ready", 1'b1, cmd_ready);
  endtask : issue

  task automatic wait_idle();
    int n;
    n = 0;
    while (flash_busy !== 1'b0 && n < 200) begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_idle

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    #(60000 * 25);
    err_total++;
    end_of_test();
  end

  initial begin
    int        exp_qe;
    logic      has;
    logic [31:0] g;
    sfx_cmd_t  k;
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = HC_STATUS;
    cmd_op = 8'h00;
    cmd_page = {PAGE_W{1'b0}};
    cmd_data = 8'h00;
    page_256 = 1'b0;
    cmp_mismatch = 1'b0;
    exp_qe = 0;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    issue(HC_CFG, OP_CFG, {PAGE_W{1'b0}}, 8'h00, 1'b0);
    chk_word("config", 32'h00000000, {24'h000000, rsp_data[7:0]});
    // Enable, disable, disable again, enable; status read while busy on odd passes
    for (int i = 0; i < 4; i++) begin
      k = (i == 0 || i == 3) ? HC_QE_ON : HC_QE_OFF;
      exp_qe = (k == HC_QE_ON);
      issue(k, OP_QE_LEAD, {PAGE_W{1'b0}}, 8'h00, i[1]);
      if (i[0]) begin
        issue(HC_STATUS, OP_STAT, {PAGE_W{1'b0}}, 8'h00, i[1]);
        chk_word("status_busy", {24'h000000, 1'b0, cmp_mismatch, DENSITY, 1'b0, i[1]}, {24'h000000, rsp_data[15:8]});
      end
      issue(HC_WAIT, OP_ASI, {PAGE_W{1'b0}}, 8'h00, i[1]);
      chk_flag("flash_busy", 1'b0, flash_busy);
      chk_flag("quad_io_enable_bit", exp_qe[0], quad_io_enable_bit);
      issue(HC_STATUS, OP_STAT, {PAGE_W{1'b0}}, 8'h00, i[1]);
      chk_word("status", {16'h0000, 1'b1, cmp_mismatch, DENSITY, 1'b0, i[1], 8'h80}, {16'h0000, rsp_data});
      issue(HC_CFG, OP_CFG, {PAGE_W{1'b0}}, 8'h00, i[1]);
      chk_word("config", {24'h000000, exp_qe[0], 7'h00}, {24'h000000, rsp_data[7:0]});
    end
    // Lead byte and both keys, then a wrong fourth byte: bit and busy must not move
    issue(HC_PAGE_OP, OP_QE_LEAD, {7'h2A, 8'h81}, 8'h00, 1'b1);
    chk_flag("quad_io_enable_bit", 1'b1, quad_io_enable_bit);
    chk_flag("flash_busy", 1'b0, flash_busy);
    // Every page opcode in both page-size modes, random page and data
    for (int m = 0; m < 2; m++) begin
      for (int j = 0; j < 6; j++) begin
        rng = xs_next(rng);
        has = (ops[j] == OP_BWR1) || (ops[j] == OP_BWR2);
        exp_q.push_back({ops[j], has, rng[PAGE_W-1:0], has ? rng[31:24] : 8'h00});
        issue(HC_PAGE_OP, ops[j], rng[PAGE_W-1:0], rng[31:24], m[0]);
        wait_idle();
        g = (got_q.size() > 0) ? got_q.pop_front() : 32'hFFFFFFFF;
        if (!has) g[7:0] = 8'h00;
        chk_word("page_op", exp_q.pop_front(), g);
        chk_word("extra_ops", 32'h00000000, got_q.size());
      end
    end
    // Config read inside the enable's busy time stays silent; the stored bit survives the reset
    issue(HC_QE_ON, OP_QE_LEAD, {PAGE_W{1'b0}}, 8'h00, 1'b0);
    issue(HC_CFG, OP_CFG, {PAGE_W{1'b0}}, 8'h00, 1'b0);
    chk_word("config_busy", 32'h00000000, {24'h000000, rsp_data[7:0]});
    issue(HC_RESET, OP_RST, {PAGE_W{1'b0}}, 8'h00, 1'b0);
    chk_word("soft_reset_count", 32'h00000001, resets_seen);
    chk_flag("flash_busy", 1'b0, flash_busy);
    chk_flag("quad_io_enable_bit", 1'b1, quad_io_enable_bit);
    end_of_test();
  end
endmodule : serial_flash_extra_cmd_decoder_bench
